/* ifch_pkg.sv */
// Constants, register indices, field positions and the state type of the IDE function configuration header.
// It assumes a host bus slave with 32-bit data, where each byte register sits in its own aligned word.
`default_nettype none
package ifch_pkg;
    // Register indices as printed; the byte address is four times the index
    localparam logic [7:0] IFCH_IDX_STAT_LO = 8'h06;
    localparam logic [7:0] IFCH_IDX_STAT_HI = 8'h07;
    localparam logic [7:0] IFCH_IDX_REV = 8'h08;
    localparam logic [7:0] IFCH_IDX_PROGIF = 8'h09;
    localparam logic [7:0] IFCH_IDX_SUBCL = 8'h0A;
    localparam logic [7:0] IFCH_IDX_CLASS = 8'h0B;
    localparam logic [7:0] IFCH_IDX_CACHE = 8'h0C;
    localparam logic [7:0] IFCH_IDX_LAT = 8'h0D;
    localparam logic [7:0] IFCH_IDX_HDR = 8'h0E;
    localparam logic [7:0] IFCH_IDX_SELF_TEST_BYTE = 8'h0F;
    localparam logic [7:0] IFCH_IDX_PBASE_A = 8'h10;
    localparam logic [7:0] IFCH_IDX_PBASE_B = 8'h14;
    localparam logic [7:0] IFCH_IDX_SBASE_A = 8'h18;
    localparam logic [7:0] IFCH_IDX_SBASE_B = 8'h1C;
    localparam logic [7:0] IFCH_IDX_BMBASE = 8'h20;
    localparam logic [7:0] IFCH_IDX_RSVD = 8'h2C;
    localparam logic [7:0] IFCH_IDX_ROM = 8'h30;
    localparam logic [7:0] IFCH_IDX_TIM_FIRST = 8'h40;
    localparam logic [7:0] IFCH_IDX_TIM_LAST = 8'h49;
    localparam int IFCH_TIM_COUNT = 10;
    localparam int IFCH_REC_COUNT = 5;
    // Status high byte fields
    localparam int IFCH_ST_MA = 5;
    localparam int IFCH_ST_RTA = 4;
    localparam int IFCH_ST_STA = 3;
    // Programming interface fields
    localparam int IFCH_PI_BM = 7;
    localparam int IFCH_PI_REPORT = 6;
    localparam int IFCH_PI_PEN = 5;
    localparam int IFCH_PI_SEN = 4;
    localparam int IFCH_PI_SPROG = 3;
    localparam int IFCH_PI_SMODE = 2;
    localparam int IFCH_PI_PPROG = 1;
    localparam int IFCH_PI_PMODE = 0;
    // Fixed values and reset values
    localparam logic [7:0] IFCH_SUBCL_VAL = 8'h01;
    localparam logic [7:0] IFCH_CLASS_VAL = 8'h01;
    localparam logic [7:0] IFCH_CACHE_VAL = 8'h00;
    localparam logic [7:0] IFCH_HDR_VAL = 8'h80;
    localparam logic [7:0] IFCH_SELF_TEST_BYTE_VAL = 8'h00;
    localparam logic [7:0] IFCH_LAT_RST = 8'h00;
    localparam logic [31:0] IFCH_BASE_RST = 32'h00000000;
    localparam logic [7:0] IFCH_TIM_RST = 8'h00;
    localparam logic [7:0] IFCH_REC_MASK = 8'h0F;
    localparam logic [7:0] IFCH_ACT_MASK = 8'h07;
    localparam logic [31:0] IFCH_BMBASE_MASK = 32'hFFFFFFF0;
    // Recovery encoding
    localparam logic [3:0] IFCH_REC_ZERO_CYC = 4'hC;
    localparam logic [3:0] IFCH_REC_LAST_LIN = 4'hB;
    localparam logic [3:0] IFCH_REC_MAX_CYC = 4'hF;
    // Bus master block offsets, 16 bytes
    localparam int IFCH_BM_BITS = 4;
    localparam logic [1:0] IFCH_BM_CMD = 2'h0;
    localparam logic [1:0] IFCH_BM_STAT = 2'h1;
    localparam logic [1:0] IFCH_BM_PTR = 2'h2;
    localparam logic [1:0] IFCH_BM_RSVD = 2'h3;

    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        logic ma;
        logic rta;
        logic sta;
        logic report;
        logic pen;
        logic sen;
        logic pmode;
        logic smode;
        logic [7:0] lat;
        logic [31:0] pba;
        logic [31:0] pbb;
        logic [31:0] sba;
        logic [31:0] sbb;
        logic [31:0] bmb;
        logic [31:0] rom;
        logic [9:0][7:0] tim;
    } ifch_state_s;

    localparam ifch_state_s IFCH_STATE_RST = '{
        ack: 1'b0, rdata: 32'h00000000, ma: 1'b0, rta: 1'b0, sta: 1'b0,
        report: 1'b1, pen: 1'b1, sen: 1'b1, pmode: 1'b0, smode: 1'b0,
        lat: IFCH_LAT_RST, pba: IFCH_BASE_RST, pbb: IFCH_BASE_RST,
        sba: IFCH_BASE_RST, sbb: IFCH_BASE_RST, bmb: IFCH_BASE_RST,
        rom: IFCH_BASE_RST, tim: {IFCH_TIM_COUNT{IFCH_TIM_RST}}
    };
endpackage
`default_nettype wire

/* ifch_recov_decode.sv */
// Turns a four-bit recovery code into a count of host bus clock cycles.
// It assumes the code comes straight from a configuration register on the same clock.
`timescale 1ns/1ns
`default_nettype none
module ifch_recov_decode
    import ifch_pkg::*;
(
    input wire logic [3:0] i_code,
    output logic [3:0] o_cycles
);
    always_comb
    begin
        if (i_code == 4'h0)
        begin
            o_cycles = IFCH_REC_ZERO_CYC; // R22
        end
        else if (i_code <= IFCH_REC_LAST_LIN)
        begin
            o_cycles = i_code; // R22
        end
        else if (i_code == IFCH_REC_MAX_CYC)
        begin
            o_cycles = IFCH_REC_MAX_CYC; // R22
        end
        else
        begin
            o_cycles = i_code + 4'h1; // R22
        end
    end
endmodule
`default_nettype wire

/* ifch_io_decode.sv */
// Host I/O address decode for the bus master block and the native-mode channel blocks.
// It assumes the I/O address and its valid come from logic on the same clock.
`timescale 1ns/1ns
`default_nettype none
module ifch_io_decode
    import ifch_pkg::*;
#(
    parameter int CHAN_BLK_BITS = 3
)
(
    input wire logic i_io_valid,
    input wire logic [31:0] i_io_addr,
    input wire logic [31:0] i_bm_base,
    input wire logic [3:0][31:0] i_chan_base,
    input wire logic [3:0] i_chan_live,
    output logic o_bm_hit,
    output logic o_bm_sec,
    output logic [1:0] o_bm_func,
    output logic [3:0] o_chan_hit
);
    logic [1:0] low_off;

    assign o_bm_hit = i_io_valid && (i_io_addr[31:IFCH_BM_BITS] == i_bm_base[31:IFCH_BM_BITS]); // R17
    assign o_bm_sec = i_io_addr[3];
    assign low_off = i_io_addr[2:1];

    always_comb
    begin
        case (low_off)
            2'h0: o_bm_func = i_io_addr[0] ? IFCH_BM_RSVD : IFCH_BM_CMD; // R17
            2'h1: o_bm_func = i_io_addr[0] ? IFCH_BM_RSVD : IFCH_BM_STAT; // R17
            default: o_bm_func = IFCH_BM_PTR; // R17
        endcase
    end

    // Compatibility channels never hit here, so stale bases stay harmless
    for (genvar g = 0; g < 4; g++)
    begin : g_chan
        assign o_chan_hit[g] = i_io_valid && i_chan_live[g]
            && (i_io_addr[31:CHAN_BLK_BITS] == i_chan_base[g][31:CHAN_BLK_BITS]); // R15 R16
    end
endmodule
`default_nettype wire

/* ifch_config_header.sv */
// Configuration header of the IDE function: an Avalon-MM slave with one wait state, abort flags,
// programming interface, class bytes, base addresses and timing bytes, plus the I/O decode they steer.
// It assumes event pulses, I/O addresses and enable permissions come from logic on i_mclk.
// Overview of operation
// R01: Own bus master transaction ending in master abort sets the master-abort flag.
// R02: The IDE interrupt request stays high while the master-abort flag is set.
// R03: Writing one clears the master-abort flag; writing zero leaves it.
// R04: Target abort received on own bus master transaction sets received-target-abort.
// R05: Terminating a transaction with target abort as target sets signaled-target-abort.
// R06: Cycles are always claimed with fast select timing; select timing field reads zero.
// R07: Programming interface bit 7 is fixed one: bus master capable.
// R08: Status reporting bit resets to one; then enable bits show real channel state.
// R09: Enable writes may be refused; reads return the real enable state.
// R10: Both channel enable bits reset to one.
// R11: Both programmable-indicator bits are fixed one.
// R12: Operating mode bits pick compatibility or native, writable, reset zero.
// R13: Subclass and class bytes read as one.
// R14: Latency timer byte is fully writable and resets to zero.
// R15: In native mode the four channel bases set the channel decode addresses.
// R16: In compatibility mode channel bases stay read-write but do not decode.
// R17: A 16-byte bus master block is decoded at its programmed base.
// R18: Boot firmware programs the bus master base before use.
// R19: Software should leave the option ROM base unprogrammed.
// R20: Ten timing bytes, recovery and active, set IDE access speed.
// R21: Recovery bytes keep four low bits; the upper four read zero.
// R22: Recovery code maps to 12, 1 to 11, 13 to 15, and 15 cycles.
// R23: Fixed bytes ignore writes and always return their constants.
//
// Added by the designer: the Avalon-MM register port.
`timescale 1ns/1ns
`default_nettype none
module ifch_config_header
    import ifch_pkg::*;
#(
    parameter logic [7:0] REVISION_CODE = 8'h5A, // Arbitrary value
    parameter int CHAN_BLK_BITS = 3
)
(
    input wire logic i_mclk,
    input wire logic i_rstn,
    input wire logic [9:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [3:0] i_avs_byteenable,
    input wire logic [31:0] i_avs_writedata,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input wire logic i_bm_master_abort,
    input wire logic i_bm_target_abort,
    input wire logic i_tgt_abort_signaled,
    input wire logic i_pri_en_change_ok,
    input wire logic i_sec_en_change_ok,
    input wire logic i_io_valid,
    input wire logic [31:0] i_io_addr,
    output logic o_ide_irq,
    output logic o_devsel_fast,
    output logic o_pri_enabled,
    output logic o_sec_enabled,
    output logic o_pri_native,
    output logic o_sec_native,
    output logic [7:0] o_latency_timer,
    output logic [19:0] o_recovery_cycles,
    output logic [14:0] o_active_code,
    output logic o_bm_hit,
    output logic o_bm_sec,
    output logic [1:0] o_bm_func,
    output logic [3:0] o_chan_hit
);
    ifch_state_s st_reg;
    ifch_state_s st_next;
    logic [7:0] idx;
    logic req;
    logic wr_fire;
    logic [3:0][31:0] chan_base;
    logic [3:0] chan_live;

    assign idx = i_avs_address[9:2];
    assign req = i_avs_read || i_avs_write;
    // One wait state lets read data come from a flip-flop
    assign o_avs_waitrequest = req && !st_reg.ack;
    assign wr_fire = i_avs_write && st_reg.ack;

    function automatic logic [31:0] ifch_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                               input logic [3:0] be);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++)
        begin
            if (be[b])
            begin
                res[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return res;
    endfunction

    always_comb
    begin
        logic [7:0] toff;
        logic [7:0] rb;
        logic [31:0] rw;
        logic byte_wr;
        toff = idx - IFCH_IDX_TIM_FIRST;
        rb = 8'h00;
        rw = 32'h00000000;
        byte_wr = wr_fire && i_avs_byteenable[0];
        st_next = st_reg;
        st_next.ack = req && !st_reg.ack;

        // Read path, captured in the wait cycle
        case (idx)
            IFCH_IDX_STAT_LO: rb = 8'h00; // R23
            IFCH_IDX_STAT_HI:
            begin
                rb = 8'h00; // R06 R23
                rb[IFCH_ST_MA] = st_reg.ma;
                rb[IFCH_ST_RTA] = st_reg.rta;
                rb[IFCH_ST_STA] = st_reg.sta;
            end
            IFCH_IDX_REV: rb = REVISION_CODE;
            IFCH_IDX_PROGIF:
            begin
                rb[IFCH_PI_BM] = 1'b1; // R07
                rb[IFCH_PI_REPORT] = st_reg.report;
                rb[IFCH_PI_PEN] = st_reg.report && st_reg.pen; // R08 R09
                rb[IFCH_PI_SEN] = st_reg.report && st_reg.sen; // R08 R09
                rb[IFCH_PI_SPROG] = 1'b1; // R11
                rb[IFCH_PI_SMODE] = st_reg.smode;
                rb[IFCH_PI_PPROG] = 1'b1; // R11
                rb[IFCH_PI_PMODE] = st_reg.pmode;
            end
            IFCH_IDX_SUBCL: rb = IFCH_SUBCL_VAL; // R13
            IFCH_IDX_CLASS: rb = IFCH_CLASS_VAL; // R13
            IFCH_IDX_CACHE: rb = IFCH_CACHE_VAL; // R23
            IFCH_IDX_LAT: rb = st_reg.lat;
            IFCH_IDX_HDR: rb = IFCH_HDR_VAL; // R23
            IFCH_IDX_SELF_TEST_BYTE: rb = IFCH_SELF_TEST_BYTE_VAL; // R23
            IFCH_IDX_PBASE_A: rw = st_reg.pba;
            IFCH_IDX_PBASE_B: rw = st_reg.pbb;
            IFCH_IDX_SBASE_A: rw = st_reg.sba;
            IFCH_IDX_SBASE_B: rw = st_reg.sbb;
            IFCH_IDX_BMBASE: rw = st_reg.bmb;
            IFCH_IDX_ROM: rw = st_reg.rom;
            default:
            begin
                // Reserved and unmapped words read zero
                if (idx >= IFCH_IDX_TIM_FIRST && idx <= IFCH_IDX_TIM_LAST)
                begin
                    rb = st_reg.tim[toff[3:0]];
                end
            end
        endcase
        if (i_avs_read && !st_reg.ack)
        begin
            st_next.rdata = rw | {24'h000000, rb};
        end

        // Write path, at the edge where waitrequest is low
        case (idx)
            IFCH_IDX_STAT_HI:
            begin
                if (byte_wr)
                begin
                    if (i_avs_writedata[IFCH_ST_MA])
                    begin
                        st_next.ma = 1'b0; // R03
                    end
                    if (i_avs_writedata[IFCH_ST_RTA])
                    begin
                        st_next.rta = 1'b0;
                    end
                    if (i_avs_writedata[IFCH_ST_STA])
                    begin
                        st_next.sta = 1'b0;
                    end
                end
            end
            IFCH_IDX_PROGIF:
            begin
                if (byte_wr)
                begin
                    st_next.report = i_avs_writedata[IFCH_PI_REPORT];
                    st_next.smode = i_avs_writedata[IFCH_PI_SMODE]; // R12
                    st_next.pmode = i_avs_writedata[IFCH_PI_PMODE]; // R12
                    // A refused change simply leaves the real state in place
                    if (i_pri_en_change_ok)
                    begin
                        st_next.pen = i_avs_writedata[IFCH_PI_PEN]; // R09
                    end
                    if (i_sec_en_change_ok)
                    begin
                        st_next.sen = i_avs_writedata[IFCH_PI_SEN]; // R09
                    end
                end
            end
            IFCH_IDX_LAT:
            begin
                if (byte_wr)
                begin
                    st_next.lat = i_avs_writedata[7:0]; // R14
                end
            end
            IFCH_IDX_PBASE_A:
            begin
                if (wr_fire)
                begin
                    st_next.pba = ifch_merge(st_reg.pba, i_avs_writedata, i_avs_byteenable); // R16
                end
            end
            IFCH_IDX_PBASE_B:
            begin
                if (wr_fire)
                begin
                    st_next.pbb = ifch_merge(st_reg.pbb, i_avs_writedata, i_avs_byteenable); // R16
                end
            end
            IFCH_IDX_SBASE_A:
            begin
                if (wr_fire)
                begin
                    st_next.sba = ifch_merge(st_reg.sba, i_avs_writedata, i_avs_byteenable); // R16
                end
            end
            IFCH_IDX_SBASE_B:
            begin
                if (wr_fire)
                begin
                    st_next.sbb = ifch_merge(st_reg.sbb, i_avs_writedata, i_avs_byteenable); // R16
                end
            end
            IFCH_IDX_BMBASE:
            begin
                if (wr_fire)
                begin
                    st_next.bmb = ifch_merge(st_reg.bmb, i_avs_writedata, i_avs_byteenable)
                        & IFCH_BMBASE_MASK; // R17
                end
            end
            IFCH_IDX_ROM:
            begin
                if (wr_fire)
                begin
                    st_next.rom = ifch_merge(st_reg.rom, i_avs_writedata, i_avs_byteenable);
                end
            end
            default:
            begin
                if (byte_wr && idx >= IFCH_IDX_TIM_FIRST && idx <= IFCH_IDX_TIM_LAST)
                begin
                    // Even bytes are recovery, odd bytes active
                    st_next.tim[toff[3:0]] = i_avs_writedata[7:0]
                        & (toff[0] ? IFCH_ACT_MASK : IFCH_REC_MASK); // R20 R21
                end
            end
        endcase

        // Hardware sets win over a clear in the same cycle
        if (i_bm_master_abort)
        begin
            st_next.ma = 1'b1; // R01
        end
        if (i_bm_target_abort)
        begin
            st_next.rta = 1'b1; // R04
        end
        if (i_tgt_abort_signaled)
        begin
            st_next.sta = 1'b1; // R05
        end
    end

    always_ff @(posedge i_mclk)
    begin
        if (!i_rstn)
        begin
            st_reg <= IFCH_STATE_RST; // R08 R10 R12 R14
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign o_avs_readdata = st_reg.rdata;
    assign o_ide_irq = st_reg.ma; // R02
    assign o_devsel_fast = 1'b1; // R06
    assign o_pri_enabled = st_reg.pen;
    assign o_sec_enabled = st_reg.sen;
    assign o_pri_native = st_reg.pmode;
    assign o_sec_native = st_reg.smode;
    assign o_latency_timer = st_reg.lat;
    assign chan_base = {st_reg.sbb, st_reg.sba, st_reg.pbb, st_reg.pba};
    assign chan_live = {{2{st_reg.smode && st_reg.sen}}, {2{st_reg.pmode && st_reg.pen}}}; // R15 R16

    for (genvar g = 0; g < IFCH_REC_COUNT; g++)
    begin : g_tim
        ifch_recov_decode u_rec (
            .i_code(st_reg.tim[2*g][3:0]),
            .o_cycles(o_recovery_cycles[g*4 +: 4])
        );
        assign o_active_code[g*3 +: 3] = st_reg.tim[2*g+1][2:0];
    end

    ifch_io_decode #(
        .CHAN_BLK_BITS(CHAN_BLK_BITS)
    ) u_dec (
        .i_io_valid(i_io_valid),
        .i_io_addr(i_io_addr),
        .i_bm_base(st_reg.bmb),
        .i_chan_base(chan_base),
        .i_chan_live(chan_live),
        .o_bm_hit(o_bm_hit),
        .o_bm_sec(o_bm_sec),
        .o_bm_func(o_bm_func),
        .o_chan_hit(o_chan_hit)
    );

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rstn);

    ma_set_a: assert property (i_bm_master_abort |=> o_ide_irq [*1]) else $error("abort flag not set"); // R01
    irq_hold_a: assert property (o_ide_irq && !wr_fire |=> o_ide_irq) else $error("irq dropped"); // R02
    ma_clear_a: assert property (wr_fire && idx == IFCH_IDX_STAT_HI && i_avs_byteenable[0]
        && i_avs_writedata[IFCH_ST_MA] && !i_bm_master_abort |=> !o_ide_irq) else $error("no clear"); // R03
    ma_keep_a: assert property (wr_fire && o_ide_irq && !i_avs_writedata[IFCH_ST_MA] |=> o_ide_irq)
        else $error("zero write cleared flag"); // R03
    rta_set_a: assert property (i_bm_target_abort |=> st_reg.rta) else $error("rta not set"); // R04
    sta_set_a: assert property (i_tgt_abort_signaled |=> st_reg.sta) else $error("sta not set"); // R05
    select_timing_field_zero_a: assert property (i_avs_read && !o_avs_waitrequest && idx == IFCH_IDX_STAT_HI
        |-> o_avs_readdata[2:1] == 2'h0 && o_avs_readdata[0] == 1'b0) else $error("timing field set"); // R06
    progif_fixed_a: assert property (i_avs_read && !o_avs_waitrequest && idx == IFCH_IDX_PROGIF
        |-> o_avs_readdata[IFCH_PI_BM] && o_avs_readdata[IFCH_PI_SPROG] && o_avs_readdata[IFCH_PI_PPROG])
        else $error("fixed interface bits"); // R07 R11
    en_refuse_a: assert property (wr_fire && idx == IFCH_IDX_PROGIF && !i_pri_en_change_ok
        |=> $stable(o_pri_enabled)) else $error("refused enable changed"); // R09
    class_val_a: assert property (i_avs_read && !o_avs_waitrequest && idx == IFCH_IDX_CLASS
        |-> o_avs_readdata == 32'h00000001) else $error("class byte"); // R13
    lat_write_a: assert property (wr_fire && idx == IFCH_IDX_LAT && i_avs_byteenable[0]
        |=> o_latency_timer == $past(i_avs_writedata[7:0])) else $error("latency write"); // R14
    compat_nodec_a: assert property (!o_pri_native |-> o_chan_hit[1:0] == 2'h0)
        else $error("compat decode hit"); // R16
    rec_upper_a: assert property (i_avs_read && !o_avs_waitrequest && idx == IFCH_IDX_TIM_FIRST
        |-> o_avs_readdata[31:4] == 28'h0000000) else $error("recovery upper bits"); // R21
    wait_one_a: assert property ($rose(req) |-> o_avs_waitrequest ##1 !o_avs_waitrequest)
        else $error("wait state count");

    ma_cov_c: cover property (i_bm_master_abort ##1 o_ide_irq);
    lat_cov_c: cover property (wr_fire && idx == IFCH_IDX_LAT);
    bm_cov_c: cover property (o_bm_hit && o_bm_func == IFCH_BM_PTR);
    native_cov_c: cover property (o_pri_native && o_chan_hit[0]);
endmodule
`default_nettype wire

/* ifch_host_model.sv */
// Host bus master model: Avalon-MM word accesses to the configuration header.
// Assumes the slave answers through waitrequest on i_mclk.
`timescale 1ns/1ns
`default_nettype none
module ifch_host_model
(
    input wire logic i_mclk,
    output logic [9:0] o_addr,
    output logic o_rd,
    output logic o_wr,
    output logic [3:0] o_be,
    output logic [31:0] o_wd,
    input wire logic [31:0] i_rdata,
    input wire logic i_wait
);
    initial
    begin
        o_addr = 10'h000;
        o_rd = 1'b0;
        o_wr = 1'b0;
        o_be = 4'h0;
        o_wd = 32'h0;
    end
    // Called right after a rising edge; holds the request until waitrequest is sampled low at a rising edge
    task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] wd,
                        output logic [31:0] rd);
        o_addr <= {idx, 2'b00};
        o_rd <= !w;
        o_wr <= w;
        o_be <= 4'hF;
        o_wd <= wd;
        @(posedge i_mclk);
        // Pre-edge values: the same ones the slave samples at this edge
        while (i_wait)
        begin
            @(posedge i_mclk);
        end
        rd = i_rdata;
    endtask
    // Released data flips so a stale value never looks valid
    task automatic idle();
        o_rd <= 1'b0;
        o_wr <= 1'b0;
        o_wd <= ~o_wd;
        @(negedge i_mclk);
    endtask
endmodule
`default_nettype wire

/* ifch_config_header_tb.sv */
// Self-checking bench for the IDE function configuration header.
// Assumes the host model drives the register bus; events and I/O addresses come from here.
`timescale 1ns/1ns
`default_nettype none
module ifch_config_header_tb;
    import ifch_pkg::*;
    localparam logic [7:0] REV = 8'h3C; // Arbitrary value
    logic i_mclk = 1'b0;
    logic i_rstn = 1'b0;
    logic [9:0] adr;
    logic [3:0] be;
    logic [31:0] wd, rdata, ioa, r, sd;
    logic rd, wr, wt, ma, ta, sa, pok, sok, iov, irq, dsf, pen, sen, pnat, snat, bmh, bms;
    logic [7:0] lat;
    logic [19:0] rec;
    logic [14:0] act;
    logic [1:0] bmf;
    logic [3:0] ch;
    int fails = 0;
    int cmp_count = 0;
    int seed = 32'h23AC1AE7;
    int cyc = 0;
    logic [7:0] tix [15] = '{8'h06, 8'h07, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h0F,
                             8'h10, 8'h20, 8'h2C, 8'h40, 8'h41};
    logic [31:0] trs [15] = '{32'h0, 32'h0, 32'(REV), 32'hFA, 32'h1, 32'h1, 32'h0, 32'h0, 32'h80,
                              32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
    logic [31:0] tw1 [15] = '{32'h0, 32'h0, 32'(REV), 32'hFF, 32'h1, 32'h1, 32'h0, 32'hFF, 32'h80,
                              32'h0, 32'hFFFFFFFF, 32'hFFFFFFF0, 32'h0, 32'hF, 32'h7};
    ifch_host_model u_host (.i_mclk(i_mclk), .o_addr(adr), .o_rd(rd), .o_wr(wr), .o_be(be),
        .o_wd(wd), .i_rdata(rdata), .i_wait(wt));
    ifch_config_header #(.REVISION_CODE(REV)) u_dut (.i_mclk(i_mclk), .i_rstn(i_rstn),
        .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_byteenable(be),
        .i_avs_writedata(wd), .o_avs_readdata(rdata), .o_avs_waitrequest(wt),
        .i_bm_master_abort(ma), .i_bm_target_abort(ta), .i_tgt_abort_signaled(sa),
        .i_pri_en_change_ok(pok), .i_sec_en_change_ok(sok), .i_io_valid(iov), .i_io_addr(ioa),
        .o_ide_irq(irq), .o_devsel_fast(dsf), .o_pri_enabled(pen), .o_sec_enabled(sen),
        .o_pri_native(pnat), .o_sec_native(snat), .o_latency_timer(lat), .o_recovery_cycles(rec),
        .o_active_code(act), .o_bm_hit(bmh), .o_bm_sec(bms), .o_bm_func(bmf), .o_chan_hit(ch));
    initial
    begin
        forever #5 i_mclk = ~i_mclk;
    end
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Far past the few hundred cycles the tests need
    always @(posedge i_mclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            fails++;
            stop_test();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            fails++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr32(input logic [7:0] i, input logic [31:0] d);
        u_host.xfer(1'b1, i, d, r);
    endtask
    task automatic rd_chk(input logic [7:0] i, input logic [31:0] e);
        u_host.xfer(1'b0, i, 32'h0, r);
        chk(r, e);
    endtask
    function automatic logic [3:0] rcyc(input logic [3:0] c);
        return (c == 4'h0) ? 4'hC : (c < 4'hC) ? c : (c == 4'hF) ? 4'hF : c + 4'h1;
    endfunction
    initial
    begin
        {ma, ta, sa, iov, ioa} = '0;
        {pok, sok} = 2'b11;
        repeat (20) @(posedge i_mclk);
        i_rstn <= 1'b1;
        @(posedge i_mclk);
        for (int k = 0; k < 15; k++) rd_chk(tix[k], trs[k]);
        for (int k = 0; k < 15; k++) wr32(tix[k], 32'hFFFFFFFF);
        for (int k = 0; k < 15; k++) rd_chk(tix[k], tw1[k]);
        u_host.idle();
        chk(32'({dsf, pen, sen, pnat, snat}), 32'h1F);
        chk(32'({act[2:0], rec}), {9'h0, 3'h7, 20'hCCCCF});
        $display("test regs end");
        for (int k = 0; k < 16; k++)
        begin
            @(posedge i_mclk);
            sd = $random(seed);
            wr32(8'h40, {sd[31:4], 4'(k)});
            wr32(8'h0D, sd);
            rd_chk(8'h40, 32'(k));
            u_host.idle();
            chk(32'(rec[3:0]), 32'(rcyc(4'(k))));
            chk(32'(lat), 32'(sd[7:0]));
        end
        $display("test timing end");
        @(posedge i_mclk);
        {ma, ta, sa} <= 3'b111;
        @(posedge i_mclk);
        {ma, ta, sa} <= 3'b000;
        @(posedge i_mclk);
        rd_chk(8'h07, 32'h38);
        wr32(8'h07, 32'h0);
        rd_chk(8'h07, 32'h38);
        u_host.idle();
        chk(32'(irq), 32'h1);
        @(posedge i_mclk);
        wr32(8'h07, 32'h20);
        rd_chk(8'h07, 32'h18);
        u_host.idle();
        chk(32'(irq), 32'h0);
        $display("test abort end");
        @(posedge i_mclk);
        pok <= 1'b0;
        wr32(8'h09, 32'hC0);
        rd_chk(8'h09, 32'hEA);
        {pok, sok} <= 2'b10;
        wr32(8'h09, 32'h3B);
        rd_chk(8'h09, 32'h8B);
        wr32(8'h09, 32'hFB);
        rd_chk(8'h09, 32'hEB);
        $display("test enable end");
        sd = $random(seed);
        wr32(8'h20, sd);
        wr32(8'h10, ~sd);
        u_host.idle();
        for (int k = 0; k < 16; k++)
        begin
            @(posedge i_mclk);
            ioa <= {sd[31:4], 4'(k)};
            iov <= 1'b1;
            @(negedge i_mclk);
            chk(32'({bmh, bms, bmf}), {29'h1, k[3], k[2] ? 2'h2 : k[0] ? 2'h3 : {1'b0, k[1]}});
        end
        @(posedge i_mclk);
        ioa <= {~sd[31:3], 3'h5};
        @(negedge i_mclk);
        chk(32'(ch), 32'h1);
        chk(32'(bmh), 32'h0);
        @(posedge i_mclk);
        wr32(8'h09, 32'hFA);
        u_host.idle();
        chk(32'(ch), 32'h0);
        $display("test decode end");
        stop_test();
    end
endmodule
`default_nettype wire
